/* core/sbf_regs.svh */
// Register offsets, field positions, reset values and timing counts for the serial buffer status block.
// Assumes inclusion by bare name from the package and the core module.
`ifndef SBF_REGS_SVH
`define SBF_REGS_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define SBF_OFF_STATUS    8'h00
`define SBF_OFF_BUF       8'h04
`define SBF_OFF_CTRL      8'h08
`define SBF_OFF_IRQ_STAT  8'h0C
`define SBF_OFF_IRQ_MASK  8'h10

// ==========================================================================
// Status fields
// ==========================================================================
`define SBF_BIT_RX_FULL   0
`define SBF_BIT_TX_FULL   1
`define SBF_BIT_TX_EMPTY  3

// ==========================================================================
// Control fields and reset values
// ==========================================================================
`define SBF_BIT_ENH       0
`define SBF_BIT_EN        1
`define SBF_CTRL_RST      2'h0
`define SBF_IRQ_W         3
`define SBF_IRQ_RST       3'h0

// ==========================================================================
// Link and buffer sizes and bus response codes
// ==========================================================================
`define SBF_WORD_W        8
`define SBF_PTR_W         2
`define SBF_BIT_CNT_LAST  3'h7
`define SBF_AXI_OKAY      2'h0
`define SBF_AXI_SLVERR    2'h2

`endif

/* core/sbf_pkg.sv */
// Types shared by the serial buffer status block.
// Assumes sbf_regs.svh is on the include path.
`include "sbf_regs.svh"

package sbf_pkg;
  typedef logic [`SBF_WORD_W-1:0] sbf_word_t;
  typedef logic [`SBF_PTR_W-1:0]  sbf_ptr_t;
  typedef enum logic [0:0] {
    SBF_W_IDLE = 1'b0,
    SBF_W_RESP = 1'b1
  } sbf_wstate_t;
endpackage

/* core/sbf_core.sv */
// Serial port buffer status logic: transmit and receive buffers, status flags, AXI4-Lite slave.
// Assumes the serial clock, select and data pins arrive asynchronously and are synchronised here.
//
// Notes on behaviour
// RQ1: The transmit-empty flag at status bit 3 sets when a word moves from the transmit buffer to the shifter.
// RQ2: Writing the shared buffer location loads the transmit buffer and clears the transmit-empty flag.
// RQ3: In standard mode a write of the shared buffer location sets the transmit-full flag at status bit 1.
// RQ4: In standard mode the transmit-full flag clears when the transmit buffer moves into the shifter.
// RQ5: In enhanced mode transmit-full is high exactly when core write pointer plus one equals shift read pointer.
// RQ6: In standard mode the receive-full flag at status bit 0 sets when a received word enters the receive buffer.
// RQ7: In standard mode reading the shared buffer location clears the receive-full flag.
// RQ8: In enhanced mode receive-full is high exactly when shift write pointer plus one equals core read pointer.
// RQ9: Status bit 2 always reads zero.
// RQ10: Enhanced mode keeps separate core and shift pointers, each advanced by its own access or transfer.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "sbf_regs.svh"

module sbf_core
  import sbf_pkg::*;
(
  input  wire logic        aclk,          // System clock, 50 MHz.
  input  wire logic        aresetn,       // Synchronous reset, active low.
  input  wire logic [7:0]  s_awaddr,      // Write address.
  input  wire logic        s_awvalid,     // Write address valid.
  output logic             s_awready,     // Write address ready.
  input  wire logic [31:0] s_wdata,       // Write data.
  input  wire logic [3:0]  s_wstrb,       // Write strobes.
  input  wire logic        s_wvalid,      // Write data valid.
  output logic             s_wready,      // Write data ready.
  output logic [1:0]       s_bresp,       // Write response.
  output logic             s_bvalid,      // Write response valid.
  input  wire logic        s_bready,      // Write response ready.
  input  wire logic [7:0]  s_araddr,      // Read address.
  input  wire logic        s_arvalid,     // Read address valid.
  output logic             s_arready,     // Read address ready.
  output logic [31:0]      s_rdata,       // Read data.
  output logic [1:0]       s_rresp,       // Read response.
  output logic             s_rvalid,      // Read data valid.
  input  wire logic        s_rready,      // Read data ready.
  input  wire logic        link_sck,      // Serial clock from the partner.
  input  wire logic        link_sel_n,    // Frame select from the partner, active low.
  input  wire logic        link_mosi,     // Serial data in.
  output logic             link_miso,     // Serial data out.
  output logic             irq            // Interrupt, active high level.
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [1:0] sck_sync;
  logic [1:0] sel_sync;
  logic [1:0] mosi_sync;
  logic       sck_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_sync  <= 2'h0;
      sel_sync  <= 2'h3;
      mosi_sync <= 2'h0;
      sck_prev  <= 1'b0;
    end else begin
      sck_sync  <= {sck_sync[0], link_sck};
      sel_sync  <= {sel_sync[0], link_sel_n};
      mosi_sync <= {mosi_sync[0], link_mosi};
      sck_prev  <= sck_sync[1];
    end
  end

  logic active;
  logic sck_rise;
  logic sck_fall;
  assign active   = !sel_sync[1];
  assign sck_rise = active && sck_sync[1] && !sck_prev;
  assign sck_fall = active && !sck_sync[1] && sck_prev;

  // ==========================================================================
  // Control register and bus decode
  // ==========================================================================
  logic [1:0]            ctrl;
  logic [`SBF_IRQ_W-1:0] irq_stat;
  logic [`SBF_IRQ_W-1:0] irq_mask;
  logic                  enh;
  assign enh = ctrl[`SBF_BIT_ENH];

  sbf_wstate_t wstate;
  logic        wr_go;
  logic        rd_go;
  logic        buf_wr;
  logic        buf_rd;
  assign s_awready = (wstate == SBF_W_IDLE) && s_awvalid && s_wvalid;
  assign s_wready  = s_awready;
  assign wr_go     = s_awready;
  assign s_arready = !s_rvalid;
  assign rd_go     = s_arvalid && s_arready;
  assign buf_wr    = wr_go && (s_awaddr == `SBF_OFF_BUF) && s_wstrb[0];
  assign buf_rd    = rd_go && (s_araddr == `SBF_OFF_BUF);

  // ==========================================================================
  // Buffers and pointers
  // ==========================================================================
  sbf_word_t tx_mem [0:(1<<`SBF_PTR_W)-1];
  sbf_word_t rx_mem [0:(1<<`SBF_PTR_W)-1];
  sbf_ptr_t  core_write_pointer;
  sbf_ptr_t  shift_read_pointer;
  sbf_ptr_t  shift_write_pointer;
  sbf_ptr_t  core_read_pointer;
  sbf_ptr_t  cwp_inc;
  sbf_ptr_t  swp_inc;
  sbf_ptr_t  tx_idx;
  sbf_ptr_t  rx_idx;
  assign cwp_inc = core_write_pointer + sbf_ptr_t'(1);
  assign swp_inc = shift_write_pointer + sbf_ptr_t'(1);
  assign tx_idx  = enh ? core_write_pointer : sbf_ptr_t'(0);
  assign rx_idx  = enh ? core_read_pointer : sbf_ptr_t'(0);

  logic tx_std_full;
  logic rx_std_full;
  logic tx_full_flag;
  logic rx_full_flag;
  logic tx_empty_flag;
  logic tx_has_data;
  logic rx_has_data;
  assign tx_full_flag = enh ? (cwp_inc == shift_read_pointer) : tx_std_full; // RQ3 RQ5
  assign rx_full_flag = enh ? (swp_inc == core_read_pointer) : rx_std_full;  // RQ6 RQ8
  assign tx_has_data  = enh ? (core_write_pointer != shift_read_pointer) : tx_std_full;
  assign rx_has_data  = enh ? (shift_write_pointer != core_read_pointer) : rx_std_full;

  // ==========================================================================
  // Shift engine
  // ==========================================================================
  sbf_word_t shift_register;
  logic [2:0] bit_cnt;
  logic       frame_start;
  logic       tx_load;
  logic       rx_done;
  logic       sel_prev;
  logic       shift_armed;
  logic       frame_end;
  assign frame_start = active && sel_prev;
  assign frame_end   = !active && !sel_prev;
  assign rx_done     = sck_rise && (bit_cnt == `SBF_BIT_CNT_LAST) && ctrl[`SBF_BIT_EN];
  // A word loaded on the last edge of one frame still waits in the shifter, so the next frame start keeps it.
  assign tx_load     = ctrl[`SBF_BIT_EN] && tx_has_data && ((frame_start && !shift_armed) || rx_done);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_prev       <= 1'b1;
      bit_cnt        <= 3'h0;
      shift_register <= sbf_word_t'(0);
      link_miso      <= 1'b0;
      shift_armed    <= 1'b0;
    end else begin
      sel_prev <= sel_sync[1];
      if (tx_load) begin
        shift_armed <= 1'b1;
      end else if (rx_done || (frame_end && (bit_cnt != 3'h0))) begin
        shift_armed <= 1'b0;
      end
      if (!active) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt        <= bit_cnt + 3'h1;
        shift_register <= {shift_register[`SBF_WORD_W-2:0], mosi_sync[1]};
      end
      if (tx_load) begin
        shift_register <= tx_mem[enh ? shift_read_pointer : sbf_ptr_t'(0)];
        link_miso      <= tx_mem[enh ? shift_read_pointer : sbf_ptr_t'(0)][`SBF_WORD_W-1];
      end else if (sck_fall) begin
        link_miso <= shift_register[`SBF_WORD_W-1];
      end
    end
  end

  sbf_word_t rx_word;
  assign rx_word = {shift_register[`SBF_WORD_W-2:0], mosi_sync[1]};

  always_ff @(posedge aclk) begin
    if (buf_wr) begin
      tx_mem[tx_idx] <= s_wdata[`SBF_WORD_W-1:0]; // RQ2
    end
    if (rx_done && !rx_full_flag) begin
      rx_mem[enh ? shift_write_pointer : sbf_ptr_t'(0)] <= rx_word;
    end
  end

  // ==========================================================================
  // Status flags and pointers
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_empty_flag <= 1'b1;
    end else if (tx_load) begin
      tx_empty_flag <= 1'b1; // RQ1
    end else if (buf_wr) begin
      tx_empty_flag <= 1'b0; // RQ2
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || enh) begin
      tx_std_full <= 1'b0;
      rx_std_full <= 1'b0;
    end else begin
      if (buf_wr) begin
        tx_std_full <= 1'b1; // RQ3
      end else if (tx_load) begin
        tx_std_full <= 1'b0; // RQ4
      end
      if (rx_done) begin
        rx_std_full <= 1'b1; // RQ6
      end else if (buf_rd) begin
        rx_std_full <= 1'b0; // RQ7
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enh) begin
      core_write_pointer  <= sbf_ptr_t'(0);
      shift_read_pointer  <= sbf_ptr_t'(0);
      shift_write_pointer <= sbf_ptr_t'(0);
      core_read_pointer   <= sbf_ptr_t'(0);
    end else begin
      if (buf_wr && !tx_full_flag) begin
        core_write_pointer <= cwp_inc; // RQ10
      end
      if (tx_load) begin
        shift_read_pointer <= shift_read_pointer + sbf_ptr_t'(1); // RQ10
      end
      if (rx_done && !rx_full_flag) begin
        shift_write_pointer <= swp_inc; // RQ10
      end
      if (buf_rd && rx_has_data) begin
        core_read_pointer <= core_read_pointer + sbf_ptr_t'(1); // RQ10
      end
    end
  end

  // ==========================================================================
  // Registers, interrupts and responses
  // ==========================================================================
  logic [`SBF_IRQ_W-1:0] irq_evt;
  logic [`SBF_IRQ_W-1:0] irq_clr;
  assign irq_evt = {tx_load, rx_done && rx_full_flag, rx_done};
  assign irq_clr = (wr_go && s_awaddr == `SBF_OFF_IRQ_STAT) ? s_wdata[`SBF_IRQ_W-1:0] : `SBF_IRQ_RST;
  assign irq     = |(irq_stat & irq_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= `SBF_CTRL_RST;
      irq_mask <= `SBF_IRQ_RST;
      irq_stat <= `SBF_IRQ_RST;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
      if (wr_go && s_awaddr == `SBF_OFF_CTRL && s_wstrb[0]) begin
        ctrl <= s_wdata[1:0];
      end
      if (wr_go && s_awaddr == `SBF_OFF_IRQ_MASK && s_wstrb[0]) begin
        irq_mask <= s_wdata[`SBF_IRQ_W-1:0];
      end
    end
  end

  logic wr_ok;
  assign wr_ok = (s_awaddr == `SBF_OFF_BUF) || (s_awaddr == `SBF_OFF_CTRL) ||
                 (s_awaddr == `SBF_OFF_IRQ_STAT) || (s_awaddr == `SBF_OFF_IRQ_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate   <= SBF_W_IDLE;
      s_bvalid <= 1'b0;
      s_bresp  <= `SBF_AXI_OKAY;
    end else begin
      case (wstate)
        SBF_W_IDLE: begin
          if (wr_go) begin
            wstate   <= SBF_W_RESP;
            s_bvalid <= 1'b1;
            s_bresp  <= wr_ok ? `SBF_AXI_OKAY : `SBF_AXI_SLVERR;
          end
        end
        SBF_W_RESP: begin
          if (s_bready) begin
            wstate   <= SBF_W_IDLE;
            s_bvalid <= 1'b0;
          end
        end
        default: wstate <= SBF_W_IDLE;
      endcase
    end
  end

  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_araddr)
      `SBF_OFF_STATUS: begin
        rd_val[`SBF_BIT_TX_EMPTY] = tx_empty_flag;
        rd_val[`SBF_BIT_TX_FULL]  = tx_full_flag;
        rd_val[`SBF_BIT_RX_FULL]  = rx_full_flag; // RQ9
      end
      `SBF_OFF_BUF:      rd_val[`SBF_WORD_W-1:0] = rx_mem[rx_idx];
      `SBF_OFF_CTRL:     rd_val[1:0] = ctrl;
      `SBF_OFF_IRQ_STAT: rd_val[`SBF_IRQ_W-1:0] = irq_stat;
      `SBF_OFF_IRQ_MASK: rd_val[`SBF_IRQ_W-1:0] = irq_mask;
      default:           rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= `SBF_AXI_OKAY;
    end else if (rd_go) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_val;
      s_rresp  <= rd_ok ? `SBF_AXI_OKAY : `SBF_AXI_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_tbe_set;
    @(posedge aclk) disable iff (!aresetn) tx_load |=> tx_empty_flag;
  endproperty
  a_tbe_set: assert property (p_tbe_set) else $error("tx empty not set on load"); // RQ1

  property p_tbe_clr;
    @(posedge aclk) disable iff (!aresetn) (buf_wr && !tx_load) |=> !tx_empty_flag;
  endproperty
  a_tbe_clr: assert property (p_tbe_clr) else $error("tx empty not cleared on write"); // RQ2

  property p_tbf_set;
    @(posedge aclk) disable iff (!aresetn) (buf_wr && !enh) ##1 !enh |-> tx_full_flag;
  endproperty
  a_tbf_set: assert property (p_tbf_set) else $error("tx full not set on write"); // RQ3

  property p_tbf_clr;
    @(posedge aclk) disable iff (!aresetn) (tx_load && !buf_wr && !enh) ##1 !enh |-> !tx_full_flag;
  endproperty
  a_tbf_clr: assert property (p_tbf_clr) else $error("tx full not cleared on load"); // RQ4

  property p_tbf_enh;
    @(posedge aclk) disable iff (!aresetn) enh |-> (tx_full_flag == (cwp_inc == shift_read_pointer));
  endproperty
  a_tbf_enh: assert property (p_tbf_enh) else $error("tx full mismatch in enhanced mode"); // RQ5

  sequence s_rx_word;
    rx_done && !enh;
  endsequence
  property p_rbf_set;
    @(posedge aclk) disable iff (!aresetn) s_rx_word ##1 !enh |-> rx_full_flag;
  endproperty
  a_rbf_set: assert property (p_rbf_set) else $error("rx full not set on receive"); // RQ6

  property p_rbf_clr;
    @(posedge aclk) disable iff (!aresetn) (buf_rd && !rx_done && !enh) ##1 !enh |-> !rx_full_flag;
  endproperty
  a_rbf_clr: assert property (p_rbf_clr) else $error("rx full not cleared on read"); // RQ7

  property p_rbf_enh;
    @(posedge aclk) disable iff (!aresetn) enh |-> (rx_full_flag == (swp_inc == core_read_pointer));
  endproperty
  a_rbf_enh: assert property (p_rbf_enh) else $error("rx full mismatch in enhanced mode"); // RQ8

  property p_bit2;
    @(posedge aclk) disable iff (!aresetn) s_rvalid && $past(rd_go) && $past(s_araddr) == `SBF_OFF_STATUS
      |-> !s_rdata[2];
  endproperty
  a_bit2: assert property (p_bit2) else $error("status bit 2 not zero"); // RQ9

  property p_srp_adv;
    @(posedge aclk) disable iff (!aresetn) (enh && tx_load) ##1 enh |-> shift_read_pointer == $past(shift_read_pointer) + sbf_ptr_t'(1);
  endproperty
  a_srp_adv: assert property (p_srp_adv) else $error("shift read pointer not advanced"); // RQ10

endmodule

/* verification/sbf_link_model.sv */
// Serial link partner: a frame master in mode 0, most significant bit first.
// Assumes the bench calls frame() and leaves the link idle between calls.
`timescale 1ns/1ns

module sbf_link_model (
  output logic      link_sck,   // Serial clock, low outside frames.
  output logic      link_sel_n, // Frame select, active low.
  output logic      link_mosi,  // Serial data to the block.
  input  wire logic link_miso   // Serial data from the block.
);
  // ==========================================================================
  // Idle levels
  // ==========================================================================
  initial begin
    link_sck = 1'h0;
    link_sel_n = 1'h1;
    link_mosi = 1'h0;
  end

  // ==========================================================================
  // One 8-bit frame at 160 ns per bit
  // ==========================================================================
  // The returned bit is taken just before the falling edge; the block moves its output after it, and also on the last rising edge when it reloads the shifter.
  task automatic frame(input logic [7:0] d, input int lag, output logic [7:0] q);
    int i;
    #7;
    link_sel_n = 1'h0;
    #(lag);
    for (i = 7; i >= 0; i--) begin
      link_mosi = d[i];
      #80;
      link_sck = 1'h1;
      #80;
      q[i] = link_miso;
      link_sck = 1'h0;
    end
    #100;
    link_sel_n = 1'h1;
    link_mosi = ~link_mosi;
  endtask
endmodule

/* verification/sbf_bench.sv */
// Self-checking bench for the serial buffer status block.
// Assumes sbf_core, sbf_pkg and the link partner model are compiled before it.
`timescale 1ns/1ns
`include "sbf_regs.svh"

module sbf_bench;
  localparam logic [1:0] OK  = `SBF_AXI_OKAY;
  localparam logic [1:0] ERR = `SBF_AXI_SLVERR;

  logic        aclk      = 1'h0;
  logic        aresetn   = 1'h0;
  logic [7:0]  s_awaddr  = 8'h00;
  logic        s_awvalid = 1'h0;
  logic [31:0] s_wdata   = 32'h0000_0000;
  logic        s_wvalid  = 1'h0;
  logic        s_bready  = 1'h0;
  logic [7:0]  s_araddr  = 8'h00;
  logic        s_arvalid = 1'h0;
  logic        s_rready  = 1'h0;
  logic        s_awready;
  logic        s_wready;
  logic        s_arready;
  logic        s_bvalid;
  logic        s_rvalid;
  logic [1:0]  s_bresp;
  logic [1:0]  s_rresp;
  logic [31:0] s_rdata;
  logic        irq;
  wire         link_sck;
  wire         link_sel_n;
  wire         link_mosi;
  wire         link_miso;
  int          n_errors    = 0;
  int          comparisons = 0;
  int          seed        = 32'h0150bdb0;
  int          i;
  logic [7:0]  d;
  logic [7:0]  r;
  logic [7:0]  q;
  logic [7:0]  dv[4];
  logic [7:0]  rv[4];

  always #10 aclk = ~aclk;

  sbf_core i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .link_sck(link_sck), .link_sel_n(link_sel_n), .link_mosi(link_mosi),
    .link_miso(link_miso), .irq(irq)
  );

  sbf_link_model i_link (
    .link_sck(link_sck), .link_sel_n(link_sel_n), .link_mosi(link_mosi), .link_miso(link_miso)
  );

  // ==========================================================================
  // Checks and expectations
  // ==========================================================================
  function automatic logic [31:0] st(input logic te, input logic tf, input logic rf);
    st = 32'h0000_0000;
    st[`SBF_BIT_TX_EMPTY] = te;
    st[`SBF_BIT_TX_FULL] = tf;
    st[`SBF_BIT_RX_FULL] = rf;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic ck_irq(input logic e);
    @(negedge aclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // ==========================================================================
  // Register bus master
  // ==========================================================================
  task automatic wr(input logic [7:0] a, input logic [31:0] dw, input logic [1:0] er);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= dw;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    @(negedge aclk);
    while (!(s_awready && s_wready)) @(negedge aclk);
    @(posedge aclk);
    s_awvalid <= 1'h0;
    s_wvalid <= 1'h0;
    @(negedge aclk);
    while (!s_bvalid) @(negedge aclk);
    chk("bresp", {30'h0, er}, {30'h0, s_bresp});
    @(posedge aclk);
    s_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    @(negedge aclk);
    while (!s_arready) @(negedge aclk);
    @(posedge aclk);
    s_arvalid <= 1'h0;
    @(negedge aclk);
    while (!s_rvalid) @(negedge aclk);
    chk("rdata", ed, s_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_rresp});
    @(posedge aclk);
    s_rready <= 1'h0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    complete_run();
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`SBF_OFF_STATUS, st(1, 0, 0), OK);
    rd(`SBF_OFF_CTRL, 32'h0000_0000, OK);
    rd(`SBF_OFF_IRQ_STAT, 32'h0000_0000, OK);
    rd(8'h14, 32'h0000_0000, ERR);
    wr(`SBF_OFF_STATUS, 32'h0000_000F, ERR);
    wr(`SBF_OFF_CTRL, 32'h0000_0002, OK);
    for (i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      r = 8'($random(seed));
      wr(`SBF_OFF_BUF, {24'h0, d}, OK);
      rd(`SBF_OFF_STATUS, st(0, 1, 0), OK);
      i_link.frame(r, 200 + i * 400, q);
      repeat (4) @(posedge aclk);
      chk("miso word", {24'h0, d}, {24'h0, q});
      rd(`SBF_OFF_STATUS, st(1, 0, 1), OK);
      rd(`SBF_OFF_IRQ_STAT, 32'h0000_0005, OK);
      ck_irq(1'h0);
      wr(`SBF_OFF_IRQ_MASK, 32'h0000_0001, OK);
      ck_irq(1'h1);
      rd(`SBF_OFF_BUF, {24'h0, r}, OK);
      rd(`SBF_OFF_STATUS, st(1, 0, 0), OK);
      wr(`SBF_OFF_IRQ_STAT, 32'h0000_0007, OK);
      ck_irq(1'h0);
      wr(`SBF_OFF_IRQ_MASK, 32'h0000_0000, OK);
    end
    wr(`SBF_OFF_CTRL, 32'h0000_0003, OK);
    for (i = 0; i < 4; i++) begin
      dv[i] = 8'($random(seed));
      wr(`SBF_OFF_BUF, {24'h0, dv[i]}, OK);
      rd(`SBF_OFF_STATUS, st(0, i >= 2, 0), OK);
    end
    for (i = 0; i < 4; i++) begin
      rv[i] = 8'($random(seed));
      i_link.frame(rv[i], 200, q);
      repeat (4) @(posedge aclk);
      if (i < 3) chk("miso word", {24'h0, dv[i]}, {24'h0, q});
      rd(`SBF_OFF_STATUS, st(1, 0, i >= 2), OK);
    end
    rd(`SBF_OFF_IRQ_STAT, 32'h0000_0007, OK);
    wr(`SBF_OFF_IRQ_MASK, 32'h0000_0002, OK);
    ck_irq(1'h1);
    wr(`SBF_OFF_IRQ_STAT, 32'h0000_0002, OK);
    ck_irq(1'h0);
    for (i = 0; i < 3; i++) begin
      rd(`SBF_OFF_BUF, {24'h0, rv[i]}, OK);
      rd(`SBF_OFF_STATUS, st(1, 0, 0), OK);
    end
    complete_run();
  end
endmodule
